// ---- rtl/fpes_pkg.sv ----
/*
 * Package for the flash program/erase host controller: register map, field positions,
 * operation codes, flash bus timing counts, state encoding and carrier structs.
 * Assumes a 100 MHz clock and a parallel NOR flash reached through its asynchronous strobes.
 */
// Contract
// - Host resumes suspended erase with resume command
// - Time-limit failure needs host reset to recover
// - Program: two unlocks, program code, address/data
// - Sector erase: six write cycles with address
// - Chip erase: six write cycles, same pattern
// - Write cycle needs chip select, write low, output high
package fpes_pkg;

    localparam int CLK_MHZ = 100;
    localparam int ADDR_W  = 26;
    localparam int DATA_W  = 16;
    localparam int CNT_W   = 16;

    // Least times, rounded up to whole cycles
    localparam int TAS_NS    = 20;
    localparam int TWP_NS    = 50;
    localparam int TWPH_NS   = 30;
    localparam int TRC_NS    = 120;
    localparam int TRP_NS    = 500;
    localparam int TREADY_NS = 20000;

    function automatic logic [CNT_W-1:0] cyc_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1)
        begin
            c = 1;
        end
        return CNT_W'(c - 1);
    endfunction : cyc_min

    localparam logic [CNT_W-1:0] TAS_CYC    = cyc_min(TAS_NS);
    localparam logic [CNT_W-1:0] TWP_CYC    = cyc_min(TWP_NS);
    localparam logic [CNT_W-1:0] TWPH_CYC   = cyc_min(TWPH_NS);
    localparam logic [CNT_W-1:0] TRC_CYC    = cyc_min(TRC_NS);
    localparam logic [CNT_W-1:0] TRP_CYC    = cyc_min(TRP_NS);
    localparam logic [CNT_W-1:0] TREADY_CYC = cyc_min(TREADY_NS);

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;

    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_NOWAIT    = 4;
    localparam int ST_BUSY        = 0;
    localparam int ST_DONE        = 1;
    localparam int ST_FAIL        = 2;
    localparam int ST_READY_BUSY  = 3;

    // Flash status word bits
    localparam int DATA_POLL_BIT   = 7;
    localparam int TOGGLE_BIT      = 6;
    localparam int TIME_LIMIT_FLAG = 5;

    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [DATA_W-1:0] CMD_RESET   = 16'h00f0;

    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_PROG   = 3'h1,
        OP_SECT   = 3'h2,
        OP_CHIP   = 3'h3,
        OP_SUSP   = 3'h4,
        OP_RESUME = 3'h5,
        OP_SWRST  = 3'h6,
        OP_HWRST  = 3'h7
    } fpes_op_e;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_WSET = 9'h002,
        S_WLOW = 9'h004,
        S_WHI  = 9'h008,
        S_RD   = 9'h010,
        S_RGAP = 9'h020,
        S_RSTL = 9'h040,
        S_RSTW = 9'h080,
        S_SPARE = 9'h100
    } fpes_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fpes_cyc_s;

endpackage : fpes_pkg

// ---- rtl/fpes_host.sv ----
/*
 * Host controller for a parallel NOR flash: software orders program, sector/chip erase,
 * suspend, resume, reads and resets through Wishbone registers; the controller runs the
 * unlock sequences on the flash strobes and polls the toggle bit until the operation ends.
 * Assumes all flash inputs are synchronous to MCLK_I and a single classic Wishbone master.
 */
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module fpes_host #(
    parameter logic [25:0] UNLOCK1_ADDR   = 26'h000_0555, // First unlock address
    parameter logic [25:0] UNLOCK2_ADDR   = 26'h000_02aa, // Second unlock address
    parameter logic [15:0] UNLOCK1_DATA   = 16'h00aa,     // First unlock data
    parameter logic [15:0] UNLOCK2_DATA   = 16'h0055,     // Second unlock data
    parameter logic [15:0] CMD_ERASE_CFG  = 16'h0080,     // Erase configuration code
    parameter logic [15:0] CMD_SECT_ERASE = 16'h0030,     // Sector erase code
    parameter logic [15:0] CMD_CHIP_ERASE = 16'h0010,     // Chip erase code
    parameter logic [15:0] CMD_SUSPEND    = 16'h00b0,     // Erase suspend code
    parameter logic [15:0] CMD_RESUME     = 16'h0030      // Erase resume code
) (
    input  wire logic        MCLK_I,            // 100 MHz clock
    input  wire logic        RSTN_I,            // Async reset, active low
    input  wire logic        WB_CYC_I,          // Wishbone cycle
    input  wire logic        WB_STB_I,          // Wishbone strobe
    input  wire logic        WB_WE_I,           // Wishbone write
    input  wire logic [7:0]  WB_ADR_I,          // Byte address
    input  wire logic [3:0]  WB_SEL_I,          // Byte lanes
    input  wire logic [31:0] WB_DAT_I,          // Write data
    output logic      [31:0] WB_DAT_O,          // Read data
    output logic             WB_ACK_O,          // Acknowledge
    output logic      [25:0] FLASH_ADDR_O,      // Flash address
    input  wire logic [15:0] FLASH_DQ_I,        // Flash data in
    output logic      [15:0] FLASH_DQ_O,        // Flash data out
    output logic             FLASH_DQ_OE_O,     // High while driving data
    output logic             FLASH_CE_N_O,      // Chip select, low active
    output logic             FLASH_WE_N_O,      // Write strobe, low active
    output logic             FLASH_OE_N_O,      // Output enable, low active
    output logic             FLASH_RESET_N_O,   // Hardware reset, low active
    input  wire logic        FLASH_READY_BUSY_I // Ready high, busy low
);

    // ==========================================================================
    // Register file
    // ==========================================================================
    logic [25:0]              addr_reg;
    logic [15:0]              wdata_reg;
    logic [15:0]              rdata;
    logic                     done_flag;
    logic                     fail_flag;
    logic                     wb_ack;
    logic [31:0]              wb_dat;
    fpes_pkg::fpes_state_e    state;
    fpes_pkg::fpes_state_e    next_state;

    wire wb_req    = WB_CYC_I & WB_STB_I;
    wire wb_wr     = wb_req & WB_WE_I & wb_ack;
    wire wr_ctrl   = wb_wr & (WB_ADR_I == fpes_pkg::REG_CTRL) & WB_SEL_I[0];
    wire wr_addr   = wb_wr & (WB_ADR_I == fpes_pkg::REG_ADDR);
    wire wr_wdata  = wb_wr & (WB_ADR_I == fpes_pkg::REG_WDATA);
    wire wr_status = wb_wr & (WB_ADR_I == fpes_pkg::REG_STATUS) & WB_SEL_I[0];
    wire busy      = (state != fpes_pkg::S_IDLE);
    wire start     = wr_ctrl & ~busy;
    wire [2:0] ctrl_op  = WB_DAT_I[fpes_pkg::CTRL_OP_LSB +: 3];
    wire ctrl_nowait    = WB_DAT_I[fpes_pkg::CTRL_NOWAIT];

    wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wire [31:0] addr_merged  = ({6'h00, addr_reg} & ~wmask) | (WB_DAT_I & wmask);
    wire [31:0] wdata_merged = ({16'h0000, wdata_reg} & ~wmask) | (WB_DAT_I & wmask);

    wire [31:0] status_word = {28'h000_0000, FLASH_READY_BUSY_I, fail_flag, done_flag, busy};
    wire [31:0] read_mux =
        (WB_ADR_I == fpes_pkg::REG_ADDR)   ? {6'h00, addr_reg}    :
        (WB_ADR_I == fpes_pkg::REG_WDATA)  ? {16'h0000, wdata_reg} :
        (WB_ADR_I == fpes_pkg::REG_STATUS) ? status_word           :
        (WB_ADR_I == fpes_pkg::REG_RDATA)  ? {16'h0000, rdata}     :
                                             32'h0000_0000;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            wb_ack <= 1'b0;
            wb_dat <= 32'h0000_0000;
        end
        else
        begin
            wb_ack <= wb_req & ~wb_ack;
            wb_dat <= read_mux;
        end
    end

    assign WB_ACK_O = wb_ack;
    assign WB_DAT_O = wb_dat;

    // ==========================================================================
    // Command sequence table
    // ==========================================================================
    fpes_pkg::fpes_op_e       cur_op;
    fpes_pkg::fpes_op_e       next_op;
    logic [2:0]               step;
    logic [2:0]               next_step;

    function automatic fpes_pkg::fpes_cyc_s seq_cyc(input fpes_pkg::fpes_op_e op, input logic [2:0] st,
                                                   input logic [25:0] a, input logic [15:0] d);
        fpes_pkg::fpes_cyc_s c;
        c = '{addr: a, data: fpes_pkg::CMD_RESET};
        unique case (op)
            fpes_pkg::OP_PROG:
            begin
                unique case (st)
                    3'd0:    c = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
                    3'd1:    c = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
                    3'd2:    c = '{addr: UNLOCK1_ADDR, data: fpes_pkg::CMD_PROGRAM};
                    default: c = '{addr: a, data: d};
                endcase
            end
            fpes_pkg::OP_SECT, fpes_pkg::OP_CHIP:
            begin
                unique case (st)
                    3'd0, 3'd3: c = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
                    3'd1, 3'd4: c = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
                    3'd2:       c = '{addr: UNLOCK1_ADDR, data: CMD_ERASE_CFG};
                    default:    c = (op == fpes_pkg::OP_SECT) ? '{addr: a, data: CMD_SECT_ERASE}
                                                              : '{addr: UNLOCK1_ADDR, data: CMD_CHIP_ERASE};
                endcase
            end
            fpes_pkg::OP_SUSP:   c = '{addr: a, data: CMD_SUSPEND};
            fpes_pkg::OP_RESUME: c = '{addr: a, data: CMD_RESUME};
            default:             c = '{addr: a, data: fpes_pkg::CMD_RESET};
        endcase
        return c;
    endfunction : seq_cyc

    wire [2:0] last_step =
        (cur_op == fpes_pkg::OP_PROG)                               ? 3'd3 :
        (cur_op == fpes_pkg::OP_SECT || cur_op == fpes_pkg::OP_CHIP) ? 3'd5 : 3'd0;
    wire poll_op = (cur_op == fpes_pkg::OP_PROG) | (cur_op == fpes_pkg::OP_SECT) |
                   (cur_op == fpes_pkg::OP_CHIP) | (cur_op == fpes_pkg::OP_SUSP) |
                   (cur_op == fpes_pkg::OP_RESUME);
    wire fpes_pkg::fpes_cyc_s next_cyc = seq_cyc(next_op, next_step, addr_reg, wdata_reg);

    // ==========================================================================
    // Flash cycle engine
    // ==========================================================================
    logic [fpes_pkg::CNT_W-1:0] cnt;
    logic [fpes_pkg::CNT_W-1:0] next_cnt;
    logic                       nowait;
    logic                       next_nowait;
    logic                       polling;
    logic                       next_polling;
    logic                       have_prev;
    logic                       next_have_prev;
    logic [15:0]                prev_dq;
    logic [15:0]                next_prev_dq;
    logic [15:0]                next_rdata;
    logic                       fail_pend;
    logic                       next_fail_pend;
    logic                       set_done;
    logic                       set_fail;

    wire cnt_zero = (cnt == '0);
    // Toggle bit compared across two separate read cycles
    wire toggled  = (FLASH_DQ_I[fpes_pkg::TOGGLE_BIT] != prev_dq[fpes_pkg::TOGGLE_BIT]);
    wire time_out = FLASH_DQ_I[fpes_pkg::TIME_LIMIT_FLAG];

    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt_zero ? cnt : cnt - 1'b1;
        next_step      = step;
        next_op        = cur_op;
        next_nowait    = nowait;
        next_polling   = polling;
        next_have_prev = have_prev;
        next_prev_dq   = prev_dq;
        next_rdata     = rdata;
        next_fail_pend = fail_pend;
        set_done       = 1'b0;
        set_fail       = 1'b0;
        unique case (state)
            fpes_pkg::S_IDLE:
            begin
                if (start)
                begin
                    next_op      = fpes_pkg::fpes_op_e'(ctrl_op);
                    next_nowait  = ctrl_nowait;
                    next_step    = 3'd0;
                    next_polling = 1'b0;
                    if (ctrl_op == fpes_pkg::OP_HWRST)
                    begin
                        next_state = fpes_pkg::S_RSTL;
                        next_cnt   = fpes_pkg::TRP_CYC;
                    end
                    else if (ctrl_op == fpes_pkg::OP_READ)
                    begin
                        next_state = fpes_pkg::S_RD;
                        next_cnt   = fpes_pkg::TRC_CYC;
                    end
                    else
                    begin
                        next_state = fpes_pkg::S_WSET;
                        next_cnt   = fpes_pkg::TAS_CYC;
                    end
                end
            end
            fpes_pkg::S_WSET:
            begin
                if (cnt_zero)
                begin
                    next_state = fpes_pkg::S_WLOW;
                    next_cnt   = fpes_pkg::TWP_CYC;
                end
            end
            fpes_pkg::S_WLOW:
            begin
                if (cnt_zero)
                begin
                    next_state = fpes_pkg::S_WHI;
                    next_cnt   = fpes_pkg::TWPH_CYC;
                end
            end
            fpes_pkg::S_WHI:
            begin
                if (cnt_zero)
                begin
                    if (step != last_step)
                    begin
                        next_step  = step + 3'd1;
                        next_state = fpes_pkg::S_WSET;
                        next_cnt   = fpes_pkg::TAS_CYC;
                    end
                    else if (poll_op && !nowait)
                    begin
                        next_polling   = 1'b1;
                        next_have_prev = 1'b0;
                        next_state     = fpes_pkg::S_RD;
                        next_cnt       = fpes_pkg::TRC_CYC;
                    end
                    else
                    begin
                        // No-wait leaves the erase window open for more sectors
                        next_state     = fpes_pkg::S_IDLE;
                        set_done       = 1'b1;
                        set_fail       = fail_pend;
                        next_fail_pend = 1'b0;
                    end
                end
            end
            fpes_pkg::S_RD:
            begin
                if (cnt_zero)
                begin
                    next_rdata   = FLASH_DQ_I;
                    next_prev_dq = FLASH_DQ_I;
                    if (!polling)
                    begin
                        next_state = fpes_pkg::S_IDLE;
                        set_done   = 1'b1;
                    end
                    // Time limit believed only when two status reads in a row show it
                    else if (!have_prev || (toggled && !(time_out && prev_dq[fpes_pkg::TIME_LIMIT_FLAG])))
                    begin
                        next_have_prev = 1'b1;
                        next_state     = fpes_pkg::S_RGAP;
                    end
                    else if (!toggled)
                    begin
                        // Flash back in read mode by itself
                        next_state = fpes_pkg::S_IDLE;
                        set_done   = 1'b1;
                    end
                    else
                    begin
                        // Stuck on time limit: recover with a reset command
                        next_fail_pend = 1'b1;
                        next_op        = fpes_pkg::OP_SWRST;
                        next_step      = 3'd0;
                        next_polling   = 1'b0;
                        next_state     = fpes_pkg::S_WSET;
                        next_cnt       = fpes_pkg::TAS_CYC;
                    end
                end
            end
            fpes_pkg::S_RGAP:
            begin
                next_state = fpes_pkg::S_RD;
                next_cnt   = fpes_pkg::TRC_CYC;
            end
            fpes_pkg::S_RSTL:
            begin
                if (cnt_zero)
                begin
                    next_state = fpes_pkg::S_RSTW;
                    next_cnt   = fpes_pkg::TREADY_CYC;
                end
            end
            fpes_pkg::S_RSTW:
            begin
                if (cnt_zero && FLASH_READY_BUSY_I)
                begin
                    next_state = fpes_pkg::S_IDLE;
                    set_done   = 1'b1;
                end
            end
            default:
            begin
                next_state = fpes_pkg::S_IDLE;
            end
        endcase
    end

    // Write strobe low only with chip select low and output enable high
    wire ce_on  = (next_state == fpes_pkg::S_WSET) | (next_state == fpes_pkg::S_WLOW) |
                  (next_state == fpes_pkg::S_RD);
    wire we_on  = (next_state == fpes_pkg::S_WLOW);
    wire oe_on  = (next_state == fpes_pkg::S_RD);
    wire drv_on = (next_state == fpes_pkg::S_WSET) | (next_state == fpes_pkg::S_WLOW) |
                  (next_state == fpes_pkg::S_WHI);

    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state     <= fpes_pkg::S_IDLE;
            cnt       <= '0;
            step      <= 3'd0;
            cur_op    <= fpes_pkg::OP_READ;
            nowait    <= 1'b0;
            polling   <= 1'b0;
            have_prev <= 1'b0;
            prev_dq   <= 16'h0000;
            rdata     <= 16'h0000;
            fail_pend <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            step      <= next_step;
            cur_op    <= next_op;
            nowait    <= next_nowait;
            polling   <= next_polling;
            have_prev <= next_have_prev;
            prev_dq   <= next_prev_dq;
            rdata     <= next_rdata;
            fail_pend <= next_fail_pend;
        end
    end

    // Sticky flags: a hardware set wins over a software clear
    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            addr_reg  <= 26'h000_0000;
            wdata_reg <= 16'h0000;
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
        end
        else
        begin
            if (wr_addr && !busy)
            begin
                addr_reg <= addr_merged[25:0];
            end
            if (wr_wdata && !busy)
            begin
                wdata_reg <= wdata_merged[15:0];
            end
            done_flag <= set_done | (done_flag & ~(wr_status & WB_DAT_I[fpes_pkg::ST_DONE]));
            fail_flag <= set_fail | (fail_flag & ~(wr_status & WB_DAT_I[fpes_pkg::ST_FAIL]));
        end
    end

    // Flash pins from flops; reset output low during reset holds the flash in read mode
    always_ff @(posedge MCLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            FLASH_ADDR_O    <= 26'h000_0000;
            FLASH_DQ_O      <= 16'h0000;
            FLASH_DQ_OE_O   <= 1'b0;
            FLASH_CE_N_O    <= 1'b1;
            FLASH_WE_N_O    <= 1'b1;
            FLASH_OE_N_O    <= 1'b1;
            FLASH_RESET_N_O <= 1'b0;
        end
        else
        begin
            FLASH_ADDR_O    <= oe_on ? addr_reg : next_cyc.addr;
            FLASH_DQ_O      <= next_cyc.data;
            FLASH_DQ_OE_O   <= drv_on;
            FLASH_CE_N_O    <= ~ce_on;
            FLASH_WE_N_O    <= ~we_on;
            FLASH_OE_N_O    <= ~oe_on;
            FLASH_RESET_N_O <= (next_state != fpes_pkg::S_RSTL);
        end
    end

endmodule : fpes_host

// ---- dv/fpes_host_monitor.sv ----
/* Port assertions for the flash host controller.
   Assumes one clock domain and binding to fpes_host. */
`timescale 1ns/1ns
module fpes_host_monitor (
    input wire logic        MCLK_I,         // Clock
    input wire logic        RSTN_I,         // Reset
    input wire logic        WB_CYC_I,       // Cycle
    input wire logic        WB_STB_I,       // Strobe
    input wire logic        WB_ACK_O,       // Ack
    input wire logic [25:0] FLASH_ADDR_O,   // Address
    input wire logic [15:0] FLASH_DQ_O,     // Data
    input wire logic        FLASH_DQ_OE_O,  // Drive
    input wire logic        FLASH_CE_N_O,   // Select
    input wire logic        FLASH_WE_N_O,   // Write
    input wire logic        FLASH_OE_N_O,   // Output
    input wire logic        FLASH_RESET_N_O // Reset
);
    // ==========
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_we_low;
        !FLASH_WE_N_O [*5] ##1 FLASH_WE_N_O;
    endsequence
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    a_write_strobes: assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_OE_N_O) else $error("bad write");
    a_no_contention: assert property (!FLASH_OE_N_O |-> !FLASH_DQ_OE_O && FLASH_WE_N_O) else $error("contention");
    a_write_drive: assert property (!FLASH_WE_N_O |-> FLASH_DQ_OE_O) else $error("data not driven");
    a_we_width: assert property ($fell(FLASH_WE_N_O) |-> s_we_low) else $error("write width");
    a_ce_setup: assert property ($fell(FLASH_WE_N_O) |-> $past(!FLASH_CE_N_O)) else $error("select setup");
    a_data_hold: assert property (!FLASH_WE_N_O && $past(!FLASH_WE_N_O) |-> $stable(FLASH_DQ_O)
        && $stable(FLASH_ADDR_O)) else $error("data moved");
    a_reset_hold: assert property ($fell(FLASH_RESET_N_O) |-> !FLASH_RESET_N_O [*8]) else $error("reset short");
endmodule : fpes_host_monitor
bind fpes_host fpes_host_monitor u_mon (.*);

// ---- dv/fpes_flash_model.sv ----
/* Behavioural flash: command decode, program, erase, status reads.
   Assumes strobes change on clk_i edges; one small sector. */
`timescale 1ns/1ns
module fpes_flash_model #(parameter int BUSY = 300) (
    input  wire logic        clk_i,   // Clock
    input  wire logic        rst_n_i, // Reset
    input  wire logic        ce_n_i,  // Select
    input  wire logic        we_n_i,  // Write
    input  wire logic        oe_n_i,  // Output
    input  wire logic [25:0] addr_i,  // Address
    input  wire logic [15:0] dq_i,    // Data in
    output logic      [15:0] dq_o,    // Data out
    output logic             rdy_o    // Ready
);
    // ==========
    logic [15:0] mem [16];
    logic [15:0] pd;
    logic [2:0]  step;
    logic        we_q, ce_q, oe_q, tog, prg;
    int          cnt, sus;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    assign rdy_o = (cnt == 0);
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            {step, cnt, sus, tog, prg, dq_o} <= '0;
            {we_q, ce_q, oe_q} <= '1;
        end
        else
        begin
            {we_q, ce_q, oe_q} <= {we_n_i, ce_n_i, oe_n_i};
            cnt <= (cnt != 0) ? cnt - 1 : 0;
            // Busy ignores commands except suspend (decoded below); F0 drops back to step 0 except at step 3, where it is programmed as data
            if (!we_q && we_n_i && !ce_q && oe_q && cnt == 0)
                case (step)
                    3'h0: step <= (dq_i[7:0] == 8'haa) ? 3'h1 : 3'h0;
                    3'h1: step <= (dq_i[7:0] == 8'h55) ? 3'h2 : 3'h0;
                    3'h2: step <= (dq_i[7:0] == 8'ha0) ? 3'h3 : (dq_i[7:0] == 8'h80) ? 3'h4 : 3'h0;
                    3'h3:
                    begin
                        mem[addr_i[3:0]] <= mem[addr_i[3:0]] & dq_i;
                        {pd, prg, cnt, step} <= {dq_i, 1'b1, BUSY, 3'h0};
                    end
                    3'h4: step <= (dq_i[7:0] == 8'haa) ? 3'h5 : 3'h0;
                    3'h5: step <= (dq_i[7:0] == 8'h55) ? 3'h6 : 3'h0;
                    default:
                    begin
                        if (dq_i[7:0] == 8'h30 || dq_i[7:0] == 8'h10)
                        begin
                            foreach (mem[i]) mem[i] <= 16'hffff;
                            {prg, cnt} <= {1'b0, BUSY};
                        end
                        step <= 3'h0;
                    end
                endcase
            // Suspend parks the remaining erase time, resume brings it back
            if (!we_q && we_n_i && !ce_q && oe_q
                && (cnt != 0 ? !prg && dq_i[7:0] == 8'hb0 : sus != 0 && dq_i[7:0] == 8'h30))
                {cnt, sus} <= {sus, cnt};
            if (oe_q && !oe_n_i)
                tog <= ~tog;
            dq_o <= (oe_n_i || ce_n_i) ? ~dq_o : (cnt != 0) ? {8'h0, prg & ~pd[7], tog, 6'h0}
                : mem[addr_i[3:0]];
        end
endmodule : fpes_flash_model

// ---- dv/fpes_host_tb_top.sv ----
/* Self-checking bench: Wishbone master, flash model, read scoreboard.
   Assumes the model busy time is well below the run ceiling. */
`timescale 1ns/1ns
module fpes_host_tb_top;
    // ==========
    logic        MCLK_I = 0, RSTN_I = 0, cyc = 0, stb = 0, we = 0, chk = 0, rdy, ack, doe, ce_n, we_n, oe_n, frn;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, got;
    logic [25:0] fa;
    logic [15:0] fdo, fdi, d1, d2;
    logic [31:0] exp_q [$];
    int          mismatches = 0, checked = 0, cycles = 0;
    always #5 MCLK_I = ~MCLK_I;
    fpes_host u_dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FLASH_ADDR_O(fa),
        .FLASH_DQ_I(fdi), .FLASH_DQ_O(fdo), .FLASH_DQ_OE_O(doe), .FLASH_CE_N_O(ce_n), .FLASH_WE_N_O(we_n),
        .FLASH_OE_N_O(oe_n), .FLASH_RESET_N_O(frn), .FLASH_READY_BUSY_I(rdy));
    fpes_flash_model u_flash (.clk_i(MCLK_I), .rst_n_i(frn), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .addr_i(fa), .dq_i(doe ? fdo : fdi), .dq_o(fdi), .rdy_o(rdy));
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        @(posedge MCLK_I);
        {cyc, stb, we, chk, adr, wdat} <= {2'b11, w, c, a, d};
        do @(posedge MCLK_I); while (ack !== 1'b1);
        got = rdat;
        {cyc, stb, we, chk} <= '0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, '0, 1'b1);
    endtask : rd
    task automatic op(input logic [4:0] o, input logic [25:0] a, input logic [15:0] d);
        wb(1'b1, fpes_pkg::REG_ADDR, 32'(a), 1'b0);
        wb(1'b1, fpes_pkg::REG_WDATA, 32'(d), 1'b0);
        wb(1'b1, fpes_pkg::REG_CTRL, 32'(o), 1'b0);
        do wb(1'b0, fpes_pkg::REG_STATUS, '0, 1'b0); while (got[fpes_pkg::ST_BUSY] !== 1'b0);
    endtask : op
    task automatic fr(input logic [25:0] a, input logic [15:0] e);
        op(3'h0, a, 16'h0000);
        rd(fpes_pkg::REG_RDATA, {16'h0000, e});
    endtask : fr
    always @(posedge MCLK_I)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            mismatches = mismatches + 1;
            complete_run();
        end
        if (ack === 1'b1 && chk === 1'b1 && exp_q.size() > 0)
        begin
            checked = checked + 1;
            if (rdat !== exp_q[0])
            begin
                $display("wrong value read data expected %h seen %h", exp_q[0], rdat);
                mismatches = mismatches + 1;
            end
            void'(exp_q.pop_front());
        end
    end
    initial
    begin
        void'($urandom(91));
        d1 = 16'($urandom);
        d2 = 16'($urandom);
        repeat (5) @(posedge MCLK_I);
        RSTN_I <= 1'b1;
        fr(26'h003, 16'hffff);
        op(3'h1, 26'h003, d1);
        rd(fpes_pkg::REG_STATUS, 32'h0000_000a);
        fr(26'h003, d1);
        op(3'h1, 26'h003, d2);
        fr(26'h003, d1 & d2);
        op(3'h2, 26'h003, 16'h0000);
        fr(26'h003, 16'hffff);
        op(5'h12, 26'h003, 16'h0000);
        rd(fpes_pkg::REG_STATUS, 32'h0000_0002);
        op(5'h14, 26'h003, 16'h0000);
        rd(fpes_pkg::REG_STATUS, 32'h0000_000a);
        op(5'h05, 26'h003, 16'h0000);
        op(3'h1, 26'h005, d1);
        op(3'h3, 26'h000, 16'h0000);
        fr(26'h005, 16'hffff);
        op(3'h1, 26'h007, d2);
        op(3'h7, 26'h000, 16'h0000);
        fr(26'h007, d2);
        op(3'h6, 26'h000, 16'h0000);
        fr(26'h007, d2);
        rd(8'h1c, 32'h0000_0000);
        @(posedge MCLK_I);
        complete_run();
    end
endmodule : fpes_host_tb_top
